// *** hdl/timer_pair_pkg.sv ***
// Constants, types and register map of the paired 8-bit timer block.
// Assumes one clock domain; shared by the top module, its checker and the bench.
package timer_pair_pkg;

	// ------------------------------------------------------------
	// Bus types
	// ------------------------------------------------------------
	typedef logic [7:0] addr_t;
	typedef logic [31:0] data_t;
	typedef logic [7:0] byte_t;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam addr_t OFS_RUN = 8'h00;
	localparam addr_t OFS_MODE = 8'h04;
	localparam addr_t OFS_LOWER_CMP = 8'h08;
	localparam addr_t OFS_UPPER_CMP = 8'h0c;
	localparam addr_t OFS_FLOP = 8'h10;
	localparam addr_t OFS_STATUS = 8'h14;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int RUN_LOWER_BIT = 0;
	localparam int RUN_UPPER_BIT = 1;
	localparam int RUN_DBUF_BIT = 2;
	localparam int MODE_LCLK_LSB = 0;
	localparam int MODE_UCLK_LSB = 2;
	localparam int MODE_PWM_LSB = 4;
	localparam int MODE_PAIR_LSB = 6;
	localparam int FLOP_TOG_BIT = 0;
	localparam int FLOP_SRC_BIT = 1;
	localparam int FLOP_CMD_LSB = 2;
	localparam int FLOP_VAL_BIT = 4;
	localparam int STAT_UCNT_LSB = 8;
	localparam int STAT_FLOP_BIT = 16;
	localparam int STAT_CMPEN_BIT = 17;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam byte_t RST_CMP = 8'h00;
	localparam logic [2:0] RST_RUN = 3'h0;
	localparam byte_t RST_MODE = 8'h00;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_DUAL8 = 2'b00,
		MODE_CASCADE16 = 2'b01,
		MODE_PULSE = 2'b10,
		MODE_PWM = 2'b11
	} pair_mode_t;

	localparam logic [1:0] UCLK_LOWER_MATCH = 2'b00;
	localparam logic [1:0] PWM_P6 = 2'b01;
	localparam logic [1:0] PWM_P7 = 2'b10;
	localparam logic [1:0] FLOP_CMD_SET = 2'b01;
	localparam logic [1:0] FLOP_CMD_CLR = 2'b10;

	// Periods as 9-bit counts; 00h compare stands for 100h
	localparam logic [8:0] PERIOD_P6 = 9'h040;
	localparam logic [8:0] PERIOD_P7 = 9'h080;
	localparam logic [8:0] PERIOD_P8 = 9'h100;

endpackage

// *** hdl/tick_select.sv ***
// Four-way selector of count ticks for one timer.
// Assumes each tap is a one-cycle pulse synchronous to pclk.
`timescale 1ns/100ps
module tick_select (
	input wire logic [1:0] sel,
	input wire logic tap0,
	input wire logic tap1,
	input wire logic tap2,
	input wire logic tap3,
	output logic tick
);
	always_comb begin
		unique case (sel)
			2'b00: tick = tap0;
			2'b01: tick = tap1;
			2'b10: tick = tap2;
			2'b11: tick = tap3;
		endcase
	end
endmodule

// *** hdl/up_counter.sv ***
// Up counter with clear priority and clock enable.
// Assumes clear and inc come from logic in the pclk domain.
`timescale 1ns/100ps
module up_counter #(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic clear,
	input wire logic inc,
	output logic [WIDTH-1:0] count
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (clk_en) begin
			if (clear) begin
				count <= '0;
			end else if (inc) begin
				count <= count + 1'b1;
			end
		end
	end
endmodule

// *** hdl/timer_pair.sv ***
// Paired 8-bit timers: dual, cascaded 16-bit, pulse and PWM modes.
// Assumes prescaler ticks arrive as one-cycle pulses on pclk, and an
// APB master drives the register port.
//
// How it works
// - Upper timer may count lower compare matches
// - Pair mode 01 cascades timers into 16 bits
// - 16-bit mode: lower overflow clocks upper timer
// - Lower compare low byte, upper compare high
// - Lower write suspends compare, upper write resumes
// - 16-bit lower match: no clear, no interrupt
// - 16-bit upper matches on each comparator pulse
// - Both match: clear both, interrupt, maybe toggle
// - Pulse mode: lower timer drives square wave
// - Pulse mode toggles on either compare match
// - Pulse mode buffer loads on upper match
// - Compare 00h means 100h, matches on overflow
// - PWM on lower timer; upper stays independent
// - PWM toggles on compare and 2^n overflow
// - PWM clears lower counter at 2^n overflow
// - PWM buffer loads at 2^n overflow
// - Mode and period select code meanings
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/100ps
module timer_pair #(
	parameter int CNT_WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire timer_pair_pkg::addr_t paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire timer_pair_pkg::data_t pwdata,
	output timer_pair_pkg::data_t prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tick_ext,
	input wire logic tick_t1,
	input wire logic tick_t4,
	input wire logic tick_t16,
	input wire logic tick_t256,
	output logic timer_output_pin,
	output logic lower_match_interrupt,
	output logic upper_match_interrupt
);
	import timer_pair_pkg::*;

	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	// Compare and period logic is built around byte-wide counters
	if (CNT_WIDTH != 8) begin : g_width_check
		$error("timer_pair supports CNT_WIDTH of 8 only");
	end

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// 00h reads as a full 100h count
	function automatic logic [8:0] cmp9(input byte_t v);
		cmp9 = (v == 8'h00) ? PERIOD_P8 : {1'b0, v};
	endfunction

	function automatic logic [8:0] pwm_period(input logic [1:0] s);
		unique case (s)
			PWM_P6: pwm_period = PERIOD_P6;
			PWM_P7: pwm_period = PERIOD_P7;
			default: pwm_period = PERIOD_P8;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic run_lower_reg;
	logic run_upper_reg;
	logic dbuf_en_reg;
	logic [1:0] lower_clk_sel_reg;
	logic [1:0] upper_clock_select;
	logic [1:0] pwm_period_select;
	pair_mode_t pair_mode_field;
	byte_t lower_compare_register;
	byte_t upper_compare_register;
	byte_t lower_buffer_reg;
	logic toggle_en_reg;
	logic toggle_src_reg;
	logic cmp_en_reg;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic access;
	logic wr_stb;
	logic mapped;
	logic wr_run;
	logic wr_mode;
	logic wr_lcmp;
	logic wr_ucmp;
	logic wr_flop;
	logic [1:0] flop_cmd;
	logic pulse_mode;

	assign access = psel && penable && !pready;
	assign wr_stb = psel && penable && pready && pwrite;
	assign mapped = (paddr == OFS_RUN) || (paddr == OFS_MODE) ||
		(paddr == OFS_LOWER_CMP) || (paddr == OFS_UPPER_CMP) ||
		(paddr == OFS_FLOP) || (paddr == OFS_STATUS);
	assign wr_run = wr_stb && (paddr == OFS_RUN);
	assign wr_mode = wr_stb && (paddr == OFS_MODE);
	assign wr_lcmp = wr_stb && (paddr == OFS_LOWER_CMP);
	assign wr_ucmp = wr_stb && (paddr == OFS_UPPER_CMP);
	assign wr_flop = wr_stb && (paddr == OFS_FLOP);
	assign flop_cmd = pwdata[FLOP_CMD_LSB +: 2];
	assign pulse_mode = (pair_mode_field == MODE_PULSE) ||
		(pair_mode_field == MODE_PWM);

	// ------------------------------------------------------------
	// Counters and tick sources
	// ------------------------------------------------------------
	logic [CNT_WIDTH-1:0] lower_up_counter;
	logic [CNT_WIDTH-1:0] upper_up_counter;
	logic lower_src;
	logic upper_src;
	logic l_tick;
	logic u_tick;
	logic [8:0] l_next;
	logic [8:0] u_next;
	logic l_hit8;
	logic l_clr;
	logic l_inc;
	logic u_clr;
	logic u_inc;
	logic l_match;
	logic u_match;
	logic ev_toggle;
	logic buf_load;
	logic irq_l;
	logic irq_u;

	tick_select u_lower_sel (
		.sel(lower_clk_sel_reg),
		.tap0(tick_ext),
		.tap1(tick_t1),
		.tap2(tick_t4),
		.tap3(tick_t16),
		.tick(lower_src)
	);

	// Tap 0 of the upper selector is the lower match, used in dual mode
	tick_select u_upper_sel (
		.sel(upper_clock_select),
		.tap0(l_hit8 && (pair_mode_field == MODE_DUAL8)),
		.tap1(tick_t1),
		.tap2(tick_t16),
		.tap3(tick_t256),
		.tick(upper_src)
	);

	assign l_tick = run_lower_reg && lower_src;
	assign u_tick = run_upper_reg && upper_src &&
		!((pair_mode_field == MODE_PWM) &&
		(upper_clock_select == UCLK_LOWER_MATCH));
	assign l_next = {1'b0, lower_up_counter} + 9'h001;
	assign u_next = {1'b0, upper_up_counter} + 9'h001;
	assign l_hit8 = l_tick && (l_next == cmp9(lower_compare_register));

	up_counter #(.WIDTH(CNT_WIDTH)) u_lower_cnt (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.clear(l_clr || !run_lower_reg),
		.inc(l_inc),
		.count(lower_up_counter)
	);

	up_counter #(.WIDTH(CNT_WIDTH)) u_upper_cnt (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.clear(u_clr || !run_upper_reg),
		.inc(u_inc),
		.count(upper_up_counter)
	);

	// ------------------------------------------------------------
	// Mode engine
	// ------------------------------------------------------------
	always_comb begin
		l_clr = 1'b0;
		l_inc = 1'b0;
		u_clr = 1'b0;
		u_inc = 1'b0;
		l_match = 1'b0;
		u_match = 1'b0;
		ev_toggle = 1'b0;
		buf_load = 1'b0;
		irq_l = 1'b0;
		irq_u = 1'b0;
		unique case (pair_mode_field)
			MODE_DUAL8: begin
				if (l_tick) begin
					if (l_hit8) begin
						l_clr = 1'b1;
						l_match = 1'b1;
						irq_l = 1'b1;
					end else begin
						l_inc = 1'b1;
					end
				end
				if (u_tick) begin
					if (u_next == cmp9(upper_compare_register)) begin
						u_clr = 1'b1;
						u_match = 1'b1;
						irq_u = 1'b1;
					end else begin
						u_inc = 1'b1;
					end
				end
				ev_toggle = toggle_src_reg ? u_match : l_match;
			end
			MODE_CASCADE16: begin
				if (l_tick) begin
					// Lower byte vs lower compare, upper vs upper
					l_match = cmp_en_reg && l_hit8;
					u_match = cmp_en_reg &&
						(upper_up_counter == upper_compare_register);
					if (l_match && u_match) begin
						l_clr = 1'b1;
						u_clr = 1'b1;
						irq_u = 1'b1;
						ev_toggle = 1'b1;
					end else begin
						l_inc = 1'b1;
						// Upper select is ignored here
						u_inc = run_upper_reg && l_next[8];
					end
				end
			end
			MODE_PULSE: begin
				// Upper run bit must be set for output to run
				if (l_tick && run_upper_reg) begin
					if (l_next == cmp9(upper_compare_register)) begin
						l_clr = 1'b1;
						ev_toggle = 1'b1;
						irq_l = 1'b1;
						buf_load = dbuf_en_reg;
					end else begin
						l_inc = 1'b1;
						// Only below upper compare can this hit
						ev_toggle = l_hit8;
					end
				end
			end
			MODE_PWM: begin
				if (l_tick) begin
					if (l_next == pwm_period(pwm_period_select)) begin
						l_clr = 1'b1;
						ev_toggle = 1'b1;
						irq_l = 1'b1;
						buf_load = dbuf_en_reg;
					end else begin
						l_inc = 1'b1;
						// Zero or out-of-period compare never hits
						ev_toggle = l_hit8;
					end
				end
				if (u_tick) begin
					if (u_next == cmp9(upper_compare_register)) begin
						u_clr = 1'b1;
						irq_u = 1'b1;
					end else begin
						u_inc = 1'b1;
					end
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{dbuf_en_reg, run_upper_reg, run_lower_reg} <= RST_RUN;
		end else if (clk_en && wr_run) begin
			run_lower_reg <= pwdata[RUN_LOWER_BIT];
			run_upper_reg <= pwdata[RUN_UPPER_BIT];
			dbuf_en_reg <= pwdata[RUN_DBUF_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lower_clk_sel_reg <= RST_MODE[MODE_LCLK_LSB +: 2];
			upper_clock_select <= RST_MODE[MODE_UCLK_LSB +: 2];
			pwm_period_select <= RST_MODE[MODE_PWM_LSB +: 2];
			pair_mode_field <= pair_mode_t'(RST_MODE[MODE_PAIR_LSB +: 2]);
		end else if (clk_en && wr_mode) begin
			lower_clk_sel_reg <= pwdata[MODE_LCLK_LSB +: 2];
			upper_clock_select <= pwdata[MODE_UCLK_LSB +: 2];
			pwm_period_select <= pwdata[MODE_PWM_LSB +: 2];
			pair_mode_field <= pair_mode_t'(pwdata[MODE_PAIR_LSB +: 2]);
		end
	end

	// ------------------------------------------------------------
	// Compare registers and buffer
	// ------------------------------------------------------------
	// A software write to the live register wins over a buffer move
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lower_compare_register <= RST_CMP;
			lower_buffer_reg <= RST_CMP;
		end else if (clk_en) begin
			if (wr_lcmp && dbuf_en_reg && pulse_mode) begin
				lower_buffer_reg <= pwdata[7:0];
			end else if (wr_lcmp) begin
				lower_compare_register <= pwdata[7:0];
				lower_buffer_reg <= pwdata[7:0];
			end
			if (buf_load && !(wr_lcmp && !(dbuf_en_reg && pulse_mode))) begin
				lower_compare_register <= lower_buffer_reg;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_compare_register <= RST_CMP;
		end else if (clk_en && wr_ucmp) begin
			upper_compare_register <= pwdata[7:0];
		end
	end

	// Low byte first: lower write blocks, upper write frees compare
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_en_reg <= 1'b1;
		end else if (clk_en) begin
			if (wr_ucmp) begin
				cmp_en_reg <= 1'b1;
			end else if (wr_lcmp) begin
				cmp_en_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Output flop
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			toggle_en_reg <= 1'b0;
			toggle_src_reg <= 1'b0;
		end else if (clk_en && wr_flop) begin
			toggle_en_reg <= pwdata[FLOP_TOG_BIT];
			toggle_src_reg <= pwdata[FLOP_SRC_BIT];
		end
	end

	// Polarity is chosen by presetting the flop before start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_output_pin <= 1'b0;
		end else if (clk_en) begin
			if (wr_flop && (flop_cmd == FLOP_CMD_SET)) begin
				timer_output_pin <= 1'b1;
			end else if (wr_flop && (flop_cmd == FLOP_CMD_CLR)) begin
				timer_output_pin <= 1'b0;
			end else if (ev_toggle && toggle_en_reg) begin
				timer_output_pin <= !timer_output_pin;
			end
		end
	end

	// ------------------------------------------------------------
	// Event pulses
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lower_match_interrupt <= 1'b0;
			upper_match_interrupt <= 1'b0;
		end else if (clk_en) begin
			lower_match_interrupt <= irq_l;
			upper_match_interrupt <= irq_u;
		end
	end

	// ------------------------------------------------------------
	// APB answer
	// ------------------------------------------------------------
	// One wait state keeps prdata and pslverr straight from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= access;
			pslverr <= access && !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (clk_en) begin
			prdata <= '0;
			if (access && !pwrite) begin
				unique case (paddr)
					OFS_RUN: begin
						prdata[RUN_LOWER_BIT] <= run_lower_reg;
						prdata[RUN_UPPER_BIT] <= run_upper_reg;
						prdata[RUN_DBUF_BIT] <= dbuf_en_reg;
					end
					OFS_MODE: begin
						prdata[MODE_LCLK_LSB +: 2] <= lower_clk_sel_reg;
						prdata[MODE_UCLK_LSB +: 2] <= upper_clock_select;
						prdata[MODE_PWM_LSB +: 2] <= pwm_period_select;
						prdata[MODE_PAIR_LSB +: 2] <= pair_mode_field;
					end
					OFS_LOWER_CMP: prdata[7:0] <= lower_compare_register;
					OFS_UPPER_CMP: prdata[7:0] <= upper_compare_register;
					OFS_FLOP: begin
						prdata[FLOP_TOG_BIT] <= toggle_en_reg;
						prdata[FLOP_SRC_BIT] <= toggle_src_reg;
						prdata[FLOP_VAL_BIT] <= timer_output_pin;
					end
					OFS_STATUS: begin
						prdata[7:0] <= lower_up_counter;
						prdata[STAT_UCNT_LSB +: 8] <= upper_up_counter;
						prdata[STAT_FLOP_BIT] <= timer_output_pin;
						prdata[STAT_CMPEN_BIT] <= cmp_en_reg;
					end
					default: prdata <= '0;
				endcase
			end
		end
	end

endmodule

// *** bench/timer_pair_checker.sv ***
// Checker for the paired timer block: bus answer, causes of pin and
// interrupt events, shadow copies of mode, upper compare and enable.
// Assumes it is bound to timer_pair and sees only its ports.
`timescale 1ns/100ps
module timer_pair_checker
	import timer_pair_pkg::*;
#(
	parameter int CNT_WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire timer_pair_pkg::addr_t paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire timer_pair_pkg::data_t pwdata,
	input wire timer_pair_pkg::data_t prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tick_ext,
	input wire logic tick_t1,
	input wire logic tick_t4,
	input wire logic tick_t16,
	input wire logic tick_t256,
	input wire logic timer_output_pin,
	input wire logic lower_match_interrupt,
	input wire logic upper_match_interrupt
);
	// ----------
	// Shadows
	// ----------
	logic any_tick;
	logic wr_done;
	logic rd_done;
	logic [7:0] mode_reg;
	logic [7:0] upper_reg;
	logic cmpen_reg;
	// Any tap may feed a counter, so any of them explains an event
	assign any_tick = tick_ext | tick_t1 | tick_t4 | tick_t16 | tick_t256;
	assign wr_done = psel & penable & pready & pwrite & clk_en;
	assign rd_done = psel & penable & pready & !pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= RST_MODE;
			upper_reg <= RST_CMP;
			cmpen_reg <= 1'b1;
		end else if (wr_done) begin
			if (paddr == OFS_MODE)
				mode_reg <= pwdata[7:0];
			if (paddr == OFS_UPPER_CMP)
				upper_reg <= pwdata[7:0];
			if (paddr == OFS_UPPER_CMP || paddr == OFS_LOWER_CMP)
				cmpen_reg <= (paddr == OFS_UPPER_CMP);
		end
	end
	// ----------
	// Assertions
	// ----------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	bus_wait_a: assert property (
		psel && penable && !pready && clk_en |=> pready)
		else $error("no bus answer one cycle after access");
	pin_cause_a: assert property (
		$changed(timer_output_pin) |-> $past(any_tick || wr_done))
		else $error("pin moved without tick or write");
	lirq_cause_a: assert property (
		lower_match_interrupt |-> $past(any_tick))
		else $error("lower interrupt without tick");
	uirq_cause_a: assert property (
		upper_match_interrupt |-> $past(any_tick))
		else $error("upper interrupt without tick");
	casc_lirq_a: assert property (
		mode_reg[7:6] == MODE_CASCADE16 |-> !lower_match_interrupt)
		else $error("lower interrupt in cascade mode");
	pulse_uirq_a: assert property (
		mode_reg[7:6] == MODE_PULSE |-> !upper_match_interrupt)
		else $error("upper interrupt in pulse mode");
	mode_read_a: assert property (
		rd_done && paddr == OFS_MODE |-> prdata == {24'h0, mode_reg})
		else $error("mode readback wrong");
	ucmp_read_a: assert property (
		rd_done && paddr == OFS_UPPER_CMP |-> prdata[7:0] == upper_reg)
		else $error("upper compare readback wrong");
	cmpen_read_a: assert property (
		rd_done && paddr == OFS_STATUS |-> prdata[STAT_CMPEN_BIT] == cmpen_reg)
		else $error("compare enable flag wrong");
	cover property (upper_match_interrupt && mode_reg[7:6] == MODE_CASCADE16);
	cover property (lower_match_interrupt && mode_reg[7:6] == MODE_PWM);
	cover property (pslverr && pready);
endmodule

bind timer_pair timer_pair_checker #(.CNT_WIDTH(CNT_WIDTH)) u_checker (
	.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.tick_ext(tick_ext), .tick_t1(tick_t1), .tick_t4(tick_t4),
	.tick_t16(tick_t16), .tick_t256(tick_t256),
	.timer_output_pin(timer_output_pin),
	.lower_match_interrupt(lower_match_interrupt),
	.upper_match_interrupt(upper_match_interrupt)
);

// *** bench/timer_pair_tb.sv ***
// Self-checking bench of the paired timer block: register table, tick
// scenarios from a table, then compare hold, buffering, reset and clock enable.
// Assumes the checker is bound; all taps tick together, a limitation.
`timescale 1ns/100ps
module timer_pair_tb;
	import timer_pair_pkg::*;
	typedef struct {
		addr_t a;
		logic w;
		data_t d;
		data_t e;
		logic r;
	} reg_row_t;
	typedef struct {
		byte_t m;
		byte_t lo;
		byte_t up;
		int n;
		int el;
		int eu;
		int et;
		int eh;
	} tick_row_t;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic tk = 1'h0;
	logic ce = 1'h1;
	logic meas = 1'h0;
	logic pin_q = 1'h0;
	addr_t paddr = 8'h00;
	data_t pwdata = 32'h0;
	data_t prdata;
	data_t rd;
	logic er;
	logic pready;
	logic pslverr;
	logic pin;
	logic lirq;
	logic uirq;
	int fails = 0;
	int tests_run = 0;
	int nl, nu, nt, nh;
	reg_row_t regs[11] = '{
		'{OFS_STATUS, 1'h0, 32'h0, 32'h20000, 1'h0},
		'{OFS_MODE, 1'h1, 32'h1ff, 32'hff, 1'h0},
		'{OFS_LOWER_CMP, 1'h1, 32'h5a, 32'h5a, 1'h0},
		'{OFS_STATUS, 1'h0, 32'h0, 32'h0, 1'h0},
		'{OFS_UPPER_CMP, 1'h1, 32'ha5, 32'ha5, 1'h0},
		'{OFS_STATUS, 1'h0, 32'h0, 32'h20000, 1'h0},
		'{OFS_FLOP, 1'h1, 32'h7, 32'h13, 1'h0},
		'{OFS_FLOP, 1'h1, 32'h8, 32'h0, 1'h0},
		'{8'h18, 1'h1, 32'hff, 32'h0, 1'h1},
		'{OFS_RUN, 1'h1, 32'hf, 32'h7, 1'h0},
		'{OFS_RUN, 1'h1, 32'h0, 32'h0, 1'h0}};
	// Mode, lower, upper, ticks, then lower irqs, upper irqs, toggles, high
	tick_row_t rows[7] = '{
		'{8'h01, 8'h03, 8'h02, 60, 20, 10, 20, 30},
		'{8'h01, 8'h00, 8'h01, 512, 2, 2, 2, 256},
		'{8'h81, 8'h02, 8'h05, 50, 10, 0, 20, 30},
		'{8'hd5, 8'h10, 8'h04, 128, 2, 32, 4, 96},
		'{8'he5, 8'h10, 8'h04, 256, 2, 64, 4, 224},
		'{8'hf5, 8'h10, 8'h04, 512, 2, 128, 4, 480},
		'{8'h4d, 8'h03, 8'h01, 518, 0, 2, 2, 259}};

	timer_pair u_dut (
		.pclk(pclk), .presetn(presetn), .clk_en(ce), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tick_ext(tk), .tick_t1(tk), .tick_t4(tk), .tick_t16(tk),
		.tick_t256(tk), .timer_output_pin(pin),
		.lower_match_interrupt(lirq), .upper_match_interrupt(uirq));

	initial begin
		forever #10 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (meas) begin
			nl += (lirq === 1'h1);
			nu += (uirq === 1'h1);
			nt += (pin !== pin_q);
			nh += (pin === 1'h1);
		end
		pin_q = pin;
	end

	// ----------
	// Tasks
	// ----------
	task automatic check(data_t seen, data_t exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Starts on an edge of its own, so back-to-back calls never collide
	task automatic apb(addr_t a, logic w, data_t d);
		@(posedge pclk);
		psel <= 1'h1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Only the watchdog ends a wait that never gets an answer
		while (pready !== 1'h1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic go(int n);
		nl = 0;
		nu = 0;
		nt = 0;
		nh = 0;
		@(posedge pclk);
		tk <= 1'h1;
		meas <= 1'h1;
		repeat (n) @(posedge pclk);
		tk <= 1'h0;
		repeat (4) @(posedge pclk);
		meas <= 1'h0;
		// Lets the last counted edge settle before the counts are read
		@(posedge pclk);
	endtask

	task automatic scen(tick_row_t t);
		apb(OFS_RUN, 1'h1, 32'h0);
		apb(OFS_MODE, 1'h1, {24'h0, t.m});
		apb(OFS_LOWER_CMP, 1'h1, {24'h0, t.lo});
		apb(OFS_UPPER_CMP, 1'h1, {24'h0, t.up});
		apb(OFS_FLOP, 1'h1, 32'h9);
		apb(OFS_RUN, 1'h1, 32'h3);
		go(t.n);
		check(nl, t.el);
		check(nu, t.eu);
		check(nt, t.et);
		check(nh, t.eh);
	endtask

	task automatic dbuf(byte_t m, int n);
		apb(OFS_RUN, 1'h1, 32'h0);
		apb(OFS_MODE, 1'h1, {24'h0, m});
		apb(OFS_LOWER_CMP, 1'h1, 32'h2);
		apb(OFS_UPPER_CMP, 1'h1, 32'h5);
		apb(OFS_RUN, 1'h1, 32'h7);
		apb(OFS_LOWER_CMP, 1'h1, 32'h4);
		apb(OFS_LOWER_CMP, 1'h0, 32'h0);
		check(rd, 32'h2);
		go(n);
		apb(OFS_LOWER_CMP, 1'h0, 32'h0);
		check(rd, 32'h4);
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------
	// Sequence
	// ----------
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		foreach (regs[i]) begin
			if (regs[i].w)
				apb(regs[i].a, 1'h1, regs[i].d);
			apb(regs[i].a, 1'h0, 32'h0);
			check(rd, regs[i].e);
			check({31'h0, er}, {31'h0, regs[i].r});
		end
		foreach (rows[i])
			scen(rows[i]);
		// Lower write alone leaves the 16-bit compare held off
		apb(OFS_RUN, 1'h1, 32'h0);
		apb(OFS_LOWER_CMP, 1'h1, 32'h3);
		apb(OFS_RUN, 1'h1, 32'h3);
		go(518);
		check(nu, 32'h0);
		apb(OFS_RUN, 1'h1, 32'h0);
		apb(OFS_UPPER_CMP, 1'h1, 32'h1);
		apb(OFS_RUN, 1'h1, 32'h3);
		go(259);
		check(nu, 32'h1);
		dbuf(8'h81, 5);
		dbuf(8'hd5, 64);
		// Second reset while counting
		apb(OFS_RUN, 1'h1, 32'h3);
		@(posedge pclk);
		tk <= 1'h1;
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		tk <= 1'h0;
		apb(OFS_STATUS, 1'h0, 32'h0);
		check(rd, 32'h20000);
		apb(OFS_MODE, 1'h0, 32'h0);
		check(rd, 32'h0);
		// Clock enable low for four ticks: only six of ten count
		apb(OFS_MODE, 1'h1, 32'h1);
		apb(OFS_RUN, 1'h1, 32'h1);
		@(posedge pclk);
		tk <= 1'h1;
		ce <= 1'h0;
		repeat (4) @(posedge pclk);
		ce <= 1'h1;
		repeat (6) @(posedge pclk);
		tk <= 1'h0;
		apb(OFS_STATUS, 1'h0, 32'h0);
		check(rd, 32'h20006);
		conclude();
	end

	// Whole run is some 3300 cycles; this is twelve times that
	initial begin
		#(20 * 40000);
		fails++;
		conclude();
	end
endmodule
